/* rtl/cwp_config_loader.sv */
module cwp_config_loader #(
  parameter logic [8:0] PART_ID = cwp_pkg::PART_ID_DFLT,  // Arbitrary value.
  parameter logic [4:0] STEP_ID = cwp_pkg::STEP_ID_DFLT   // Arbitrary value.
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_sleep,
  input  wire logic        i_software_watchdog_on,
  input  wire logic        i_stack_fault,
  input  wire logic        i_ext_pm_rd,
  input  wire logic        i_ext_pm_wr,
  input  wire logic [13:0] i_pm_rdata,
  input  wire logic        i_ext_ee_rd,
  input  wire logic        i_ext_ee_wr,
  input  wire logic        i_cpu_ee_rd,
  input  wire logic        i_cpu_ee_wr,
  input  wire logic        i_self_wr_req,
  input  wire logic [11:0] i_self_wr_addr,
  output logic      [13:0] o_ext_pm_rdata,
  output logic             o_ext_pm_wr_en,
  output logic      [13:0] o_cpu_pm_rdata,
  output logic             o_ext_ee_rd_en,
  output logic             o_ext_ee_wr_en,
  output logic             o_cpu_ee_rd_en,
  output logic             o_cpu_ee_wr_en,
  output logic             o_self_wr_en,
  output logic             o_pm_erase,
  output logic             o_ee_erase,
  output logic             o_watchdog_run,
  output logic      [1:0]  o_watchdog_enable_mode,
  output logic      [2:0]  o_clock_source_select,
  output logic             o_clock_input_pin_is_io,
  output logic             o_ext_clock,
  output logic             o_external_rc_mode,
  output logic             o_crystal_pins_used,
  output logic      [1:0]  o_drive_level,
  output logic             o_powerup_timer_en,
  output logic      [1:0]  o_brownout_mode,
  output logic             o_brownout_trip_select,
  output logic             o_low_volt_programming_enable,
  output logic             o_debug_en,
  output logic             o_clock_multiplier_enable,
  output logic             o_stack_reset
);

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Word index of a byte address; the two low address bits are ignored, so unaligned accesses decode too.
  function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
    hit = (addr[31:18] == 14'h0000) && (addr[17:2] == idx);
  endfunction

  // Lowest self-writable address for each guard setting.
  function automatic logic [12:0] guard_limit(input logic [1:0] sel);
    case (sel)
      2'b11:   guard_limit = cwp_pkg::GUARD_NONE;
      2'b10:   guard_limit = cwp_pkg::GUARD_SMALL;
      2'b01:   guard_limit = cwp_pkg::GUARD_HALF;
      default: guard_limit = cwp_pkg::GUARD_ALL;
    endcase
  endfunction

  cwp_mem_if mem_bus ();

  cwp_id_mem u_id_mem (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .port      (mem_bus.mem)
  );

  logic [13:0] cfg_one_r;
  logic [13:0] cfg_two_r;
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [31:0] addr_r;
  logic        addr_phase;
  logic        wr_cfg_one;
  logic        wr_cfg_two;
  logic        wr_erase;
  logic [13:0] cfg_one_nxt;
  logic [13:0] cfg_two_nxt;
  logic [13:0] part_word;
  logic        prog_open;
  logic        ee_open;
  logic [12:0] self_addr;

  assign addr_phase = i_hsel && i_htrans[1] && i_hready;
  assign part_word  = {PART_ID, STEP_ID};
  assign prog_open  = cfg_one_r[cwp_pkg::CW1_PROG_PROT];
  assign ee_open    = cfg_one_r[cwp_pkg::CW1_EEPROM_PROT];
  assign self_addr  = {1'b0, i_self_wr_addr};

  // ==========================================================================
  // Bus slave. Writes finish with no wait; reads insert one wait state so the
  // read word comes out of a register, as the store's output is itself registered.
  // ==========================================================================
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= '0;
    end else begin
      wr_pend_r <= addr_phase && i_hwrite;
      rd_pend_r <= addr_phase && !i_hwrite;
      if (addr_phase) begin
        addr_r <= i_haddr;
      end
    end
  end

  // Ready drops only for the first data-phase cycle of a read.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= !(addr_phase && !i_hwrite);
      o_hresp     <= 1'b0;
    end
  end

  // Read mux; unmapped words and the bus bits above each word read as zero.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hrdata <= '0;
    end else if (rd_pend_r) begin
      if (addr_r[17:4] == cwp_pkg::IDX_USER_ID0[15:2] && addr_r[31:18] == 14'h0000) begin
        o_hrdata <= {18'h0_0000, mem_bus.rdata};
      end else if (hit(addr_r, cwp_pkg::IDX_PART_ID)) begin
        o_hrdata <= {18'h0_0000, part_word};
      end else if (hit(addr_r, cwp_pkg::IDX_CFG_ONE)) begin
        o_hrdata <= {18'h0_0000, cfg_one_r};
      end else if (hit(addr_r, cwp_pkg::IDX_CFG_TWO)) begin
        o_hrdata <= {18'h0_0000, cfg_two_r};
      end else if (hit(addr_r, cwp_pkg::IDX_STATUS)) begin
        o_hrdata <= {26'h000_0000, o_stack_reset, o_clock_multiplier_enable, o_watchdog_run,
                     o_self_wr_en, !ee_open, !prog_open};
      end else begin
        o_hrdata <= '0;
      end
    end
  end

  // User ID store port: read address from the address phase, write in the data phase.
  assign mem_bus.raddr = i_haddr[3:2];
  assign mem_bus.we    = wr_pend_r && (addr_r[31:18] == 14'h0000)
                         && (addr_r[17:4] == cwp_pkg::IDX_USER_ID3[15:2]);
  assign mem_bus.waddr = addr_r[3:2];
  assign mem_bus.wdata = i_hwdata[13:0];

  // ==========================================================================
  // Configuration words. A direct write may lift program protection, which
  // erases program memory; data protection can only be lifted by bulk erase,
  // so the EEPROM is always wiped before its contents become readable.
  // ==========================================================================
  assign wr_cfg_one = wr_pend_r && hit(addr_r, cwp_pkg::IDX_CFG_ONE);
  assign wr_cfg_two = wr_pend_r && hit(addr_r, cwp_pkg::IDX_CFG_TWO);
  assign wr_erase   = wr_pend_r && hit(addr_r, cwp_pkg::IDX_LOAD_CTRL)
                      && i_hwdata[cwp_pkg::LOAD_BULK_ERASE];

  always_comb begin
    cfg_one_nxt = cfg_one_r;
    cfg_two_nxt = cfg_two_r;
    if (wr_erase) begin
      cfg_one_nxt = cwp_pkg::CFG_ERASED;
      cfg_two_nxt = cwp_pkg::CFG_ERASED;
    end else begin
      if (wr_cfg_one) begin
        cfg_one_nxt = i_hwdata[13:0];
        cfg_one_nxt[cwp_pkg::CW1_EEPROM_PROT] = i_hwdata[cwp_pkg::CW1_EEPROM_PROT] && ee_open;
      end
      if (wr_cfg_two) begin
        cfg_two_nxt = i_hwdata[13:0] | ~cwp_pkg::CFG_TWO_WMASK;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_one_r <= cwp_pkg::CFG_ERASED;
      cfg_two_r <= cwp_pkg::CFG_ERASED;
    end else begin
      cfg_one_r <= cfg_one_nxt;
      cfg_two_r <= cfg_two_nxt;
    end
  end

  // Erase pulses fire in the same cycle the protection bit is lifted.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pm_erase <= 1'b0;
      o_ee_erase <= 1'b0;
    end else begin
      o_pm_erase <= !prog_open && cfg_one_nxt[cwp_pkg::CW1_PROG_PROT];
      o_ee_erase <= wr_erase && !ee_open;
    end
  end

  // ==========================================================================
  // External and internal access gating.
  // ==========================================================================
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ext_pm_rdata <= '0;
      o_ext_pm_wr_en <= 1'b0;
      o_ext_ee_rd_en <= 1'b0;
      o_ext_ee_wr_en <= 1'b0;
    end else begin
      o_ext_pm_rdata <= (i_ext_pm_rd && prog_open) ? i_pm_rdata : 14'h0000;
      o_ext_pm_wr_en <= i_ext_pm_wr && prog_open;
      o_ext_ee_rd_en <= i_ext_ee_rd && ee_open;
      o_ext_ee_wr_en <= i_ext_ee_wr && ee_open;
    end
  end

  // CPU paths ignore both protect bits; only the guard limits self-writes.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cpu_pm_rdata <= '0;
      o_cpu_ee_rd_en <= 1'b0;
      o_cpu_ee_wr_en <= 1'b0;
      o_self_wr_en   <= 1'b0;
    end else begin
      o_cpu_pm_rdata <= i_pm_rdata;
      o_cpu_ee_rd_en <= i_cpu_ee_rd;
      o_cpu_ee_wr_en <= i_cpu_ee_wr;
      o_self_wr_en   <= i_self_wr_req
                        && (self_addr >= guard_limit(cfg_two_r[cwp_pkg::CW2_GUARD_HI:cwp_pkg::CW2_GUARD_LO]));
    end
  end

  // ==========================================================================
  // Decoded fields for the watchdog, oscillator and reset logic.
  // ==========================================================================
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_watchdog_enable_mode <= 2'b00;
      o_watchdog_run         <= 1'b0;
    end else begin
      o_watchdog_enable_mode <= cfg_one_r[cwp_pkg::CW1_WDT_HI:cwp_pkg::CW1_WDT_LO];
      case (cwp_pkg::cwp_wdt_mode_t'(cfg_one_r[cwp_pkg::CW1_WDT_HI:cwp_pkg::CW1_WDT_LO]))
        cwp_pkg::WDT_ALWAYS:   o_watchdog_run <= 1'b1;
        cwp_pkg::WDT_AWAKE:    o_watchdog_run <= !i_sleep;
        cwp_pkg::WDT_SOFTWARE: o_watchdog_run <= i_software_watchdog_on;
        default:               o_watchdog_run <= 1'b0;
      endcase
    end
  end

  // Pin roles and drive strength of the selected clock source.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_clock_source_select   <= 3'b000;
      o_clock_input_pin_is_io <= 1'b0;
      o_ext_clock             <= 1'b0;
      o_external_rc_mode      <= 1'b0;
      o_crystal_pins_used     <= 1'b0;
      o_drive_level           <= 2'b00;
    end else begin
      o_clock_source_select   <= cfg_one_r[cwp_pkg::CW1_OSC_HI:cwp_pkg::CW1_OSC_LO];
      o_clock_input_pin_is_io <= 1'b0;
      o_ext_clock             <= 1'b0;
      o_external_rc_mode      <= 1'b0;
      o_crystal_pins_used     <= 1'b0;
      o_drive_level           <= cwp_pkg::DRIVE_NONE;
      case (cwp_pkg::cwp_osc_t'(cfg_one_r[cwp_pkg::CW1_OSC_HI:cwp_pkg::CW1_OSC_LO]))
        cwp_pkg::OSC_EXT_HIGH: begin
          o_ext_clock   <= 1'b1;
          o_drive_level <= cwp_pkg::DRIVE_HIGH;
        end
        cwp_pkg::OSC_EXT_MEDIUM: begin
          o_ext_clock   <= 1'b1;
          o_drive_level <= cwp_pkg::DRIVE_MEDIUM;
        end
        cwp_pkg::OSC_EXT_LOW: begin
          o_ext_clock   <= 1'b1;
          o_drive_level <= cwp_pkg::DRIVE_LOW;
        end
        cwp_pkg::OSC_INTERNAL:   o_clock_input_pin_is_io <= 1'b1;
        cwp_pkg::OSC_EXT_RC:     o_external_rc_mode      <= 1'b1;
        cwp_pkg::OSC_FAST_XTAL: begin
          o_crystal_pins_used <= 1'b1;
          o_drive_level       <= cwp_pkg::DRIVE_HIGH;
        end
        cwp_pkg::OSC_MEDIUM_XTAL: begin
          o_crystal_pins_used <= 1'b1;
          o_drive_level       <= cwp_pkg::DRIVE_MEDIUM;
        end
        default: begin
          o_crystal_pins_used <= 1'b1;
          o_drive_level       <= cwp_pkg::DRIVE_LOW;
        end
      endcase
    end
  end

  // Reset sources; power-up timer and brown-out stay independent on purpose.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_powerup_timer_en            <= 1'b0;
      o_brownout_mode               <= 2'b00;
      o_brownout_trip_select        <= 1'b0;
      o_low_volt_programming_enable <= 1'b0;
      o_debug_en                    <= 1'b0;
      o_clock_multiplier_enable     <= 1'b0;
      o_stack_reset                 <= 1'b0;
    end else begin
      o_powerup_timer_en            <= !cfg_one_r[cwp_pkg::CW1_PWRUP_TMR_N];
      o_brownout_mode               <= cfg_one_r[cwp_pkg::CW1_BOR_HI:cwp_pkg::CW1_BOR_LO];
      o_brownout_trip_select        <= cfg_two_r[cwp_pkg::CW2_BOR_TRIP];
      o_low_volt_programming_enable <= cfg_two_r[cwp_pkg::CW2_LOW_VOLT_PGM];
      o_debug_en                    <= !cfg_two_r[cwp_pkg::CW2_DEBUG_N];
      o_clock_multiplier_enable     <= cfg_two_r[cwp_pkg::CW2_MULT_EN];
      o_stack_reset                 <= i_stack_fault && cfg_two_r[cwp_pkg::CW2_STACK_RST];
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  sequence s_prog_unlock;
    !prog_open ##1 prog_open;
  endsequence

  sequence s_read_part;
    addr_phase && !i_hwrite && hit(i_haddr, cwp_pkg::IDX_PART_ID) ##2 o_hreadyout;
  endsequence

  a_pm_read_zero: assert property (i_ext_pm_rd && !prog_open |=> o_ext_pm_rdata == 14'h0000)
    else $error("protected program read returned data");
  a_pm_write_block: assert property (i_ext_pm_wr |=> o_ext_pm_wr_en == $past(prog_open))
    else $error("external program write gating wrong");
  a_ee_refuse: assert property (!ee_open && (i_ext_ee_rd || i_ext_ee_wr) |=> !o_ext_ee_rd_en && !o_ext_ee_wr_en)
    else $error("protected eeprom access granted");
  a_cpu_read_pass: assert property (i_reset_n |=> o_cpu_pm_rdata == $past(i_pm_rdata))
    else $error("cpu program read altered");
  a_wdt_awake: assert property (cfg_one_r[4:3] == 2'b10 |=> o_watchdog_run == !$past(i_sleep))
    else $error("watchdog awake mode wrong");
  a_prog_erase_on: assert property (s_prog_unlock |-> o_pm_erase)
    else $error("program erase missing on unlock");
  a_ee_erase_on: assert property (wr_erase && !ee_open |=> o_ee_erase && ee_open)
    else $error("eeprom erase missing on unlock");
  a_part_read: assert property (s_read_part |-> o_hrdata == {18'h0_0000, part_word})
    else $error("identity word read wrong");
  a_stack_gate: assert property (i_stack_fault && !cfg_two_r[9] |=> !o_stack_reset)
    else $error("stack reset while disabled");
  a_mult_follow: assert property (i_reset_n |=> o_clock_multiplier_enable == $past(cfg_two_r[8]))
    else $error("clock multiplier not following word");
  a_self_guard: assert property (i_self_wr_req && cfg_two_r[1:0] == 2'b00 |=> !o_self_wr_en)
    else $error("self write inside full guard");

endmodule // cwp_config_loader

/* common/cwp_pkg.sv */
package cwp_pkg;

  // ==========================================================================
  // Register map: word indices; the bus byte address is four times the index.
  // ==========================================================================
  localparam logic [15:0] IDX_USER_ID0   = 16'h8000;
  localparam logic [15:0] IDX_USER_ID3   = 16'h8003;
  localparam logic [15:0] IDX_PART_ID    = 16'h8006;
  localparam logic [15:0] IDX_CFG_ONE    = 16'h8007;
  localparam logic [15:0] IDX_CFG_TWO    = 16'h8008;
  localparam logic [15:0] IDX_LOAD_CTRL  = 16'h8010;
  localparam logic [15:0] IDX_STATUS     = 16'h8011;

  // ==========================================================================
  // Word widths and reset values.
  // ==========================================================================
  localparam int          WORD_W         = 14;
  localparam logic [13:0] CFG_ERASED     = 14'h3fff;
  localparam logic [13:0] CFG_TWO_WMASK  = 14'h3703;
  localparam logic [8:0]  PART_ID_DFLT   = 9'h0a5;  // Arbitrary value.
  localparam logic [4:0]  STEP_ID_DFLT   = 5'h01;   // Arbitrary value.

  // ==========================================================================
  // Field positions of the first configuration word.
  // ==========================================================================
  localparam int CW1_EEPROM_PROT  = 8;
  localparam int CW1_PROG_PROT    = 7;
  localparam int CW1_PWRUP_TMR_N  = 5;
  localparam int CW1_WDT_HI       = 4;
  localparam int CW1_WDT_LO       = 3;
  localparam int CW1_OSC_HI       = 2;
  localparam int CW1_OSC_LO       = 0;
  localparam int CW1_BOR_HI       = 10;
  localparam int CW1_BOR_LO       = 9;

  // ==========================================================================
  // Field positions of the second configuration word.
  // ==========================================================================
  localparam int CW2_LOW_VOLT_PGM = 13;
  localparam int CW2_DEBUG_N      = 12;
  localparam int CW2_BOR_TRIP     = 10;
  localparam int CW2_STACK_RST    = 9;
  localparam int CW2_MULT_EN      = 8;
  localparam int CW2_GUARD_HI     = 1;
  localparam int CW2_GUARD_LO     = 0;

  // Load control bit: bulk erase of both configuration words.
  localparam int LOAD_BULK_ERASE  = 0;

  // ==========================================================================
  // Self-write guard limits: addresses below the limit are shielded.
  // ==========================================================================
  localparam logic [12:0] GUARD_NONE    = 13'h0000;
  localparam logic [12:0] GUARD_SMALL   = 13'h0200;
  localparam logic [12:0] GUARD_HALF    = 13'h0800;
  localparam logic [12:0] GUARD_ALL     = 13'h1000;

  // Watchdog enable modes.
  typedef enum logic [1:0] {
    WDT_OFF       = 2'b00,
    WDT_SOFTWARE  = 2'b01,
    WDT_AWAKE     = 2'b10,
    WDT_ALWAYS    = 2'b11
  } cwp_wdt_mode_t;

  // Clock source selections.
  typedef enum logic [2:0] {
    OSC_WATCH_XTAL  = 3'b000,
    OSC_MEDIUM_XTAL = 3'b001,
    OSC_FAST_XTAL   = 3'b010,
    OSC_EXT_RC      = 3'b011,
    OSC_INTERNAL    = 3'b100,
    OSC_EXT_LOW     = 3'b101,
    OSC_EXT_MEDIUM  = 3'b110,
    OSC_EXT_HIGH    = 3'b111
  } cwp_osc_t;

  // Drive level of the oscillator amplifier or external clock buffer.
  typedef enum logic [1:0] {
    DRIVE_NONE   = 2'b00,
    DRIVE_LOW    = 2'b01,
    DRIVE_MEDIUM = 2'b10,
    DRIVE_HIGH   = 2'b11
  } cwp_drive_t;

endpackage

/* common/cwp_mem_if.sv */
// ============================================================================
// Port between the loader and its identification word store.
// ============================================================================
interface cwp_mem_if;
  logic        we;
  logic [1:0]  waddr;
  logic [13:0] wdata;
  logic [1:0]  raddr;
  logic [13:0] rdata;

  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* rtl/cwp_id_mem.sv */
// ============================================================================
// Four user identification words with a registered read port.
// ============================================================================
module cwp_id_mem (
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  cwp_mem_if.mem    port
);

  logic [13:0] words [0:3];
  logic [13:0] rdata_r;

  // Contents are non-volatile by nature, so they carry no reset.
  always_ff @(posedge i_mclk) begin
    if (port.we) begin
      words[port.waddr] <= port.wdata;
    end
  end

  // A write to the word being read is forwarded so the reader never sees stale data.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_r <= '0;
    end else if (port.we && (port.waddr == port.raddr)) begin
      rdata_r <= port.wdata;
    end else begin
      rdata_r <= words[port.raddr];
    end
  end

  assign port.rdata = rdata_r;

endmodule // cwp_id_mem

/* tb/cwp_prog_model.sv */
// ============================================================================
// External programmer model: turns each go request into access strobes.
// ============================================================================
module cwp_prog_model #(
  parameter logic [13:0] DATA = 14'h2d4b
) (
  input  wire logic        i_mclk,
  input  wire logic        i_go,
  output logic      [3:0]  o_strobe,
  output logic      [13:0] o_pm_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Strobes last one cycle, launched just after the edge that sees go.
  always @(posedge i_mclk) o_strobe <= {4{i_go}};
  // The array is held at one word, so a gated read must show zero instead.
  assign o_pm_rdata = DATA;
endmodule // cwp_prog_model

/* tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] PM = 14'h2d4b;
  logic        i_mclk = 0, i_reset_n = 0, i_hsel = 0, i_hwrite = 0, i_sleep = 0, go = 0;
  logic        i_software_watchdog_on = 0, i_stack_fault = 0, i_cpu_ee_rd = 0, i_cpu_ee_wr = 0;
  logic        i_self_wr_req = 0, o_hreadyout, o_hresp, pm_seen = 0, ee_seen = 0;
  logic [1:0]  i_htrans = 0, o_watchdog_enable_mode, o_drive_level, o_brownout_mode;
  logic [2:0]  i_hsize = 3'h2, o_clock_source_select;
  logic [11:0] i_self_wr_addr = 0;
  logic [11:0] sa [5] = '{12'h01ff, 12'h0200, 12'h07ff, 12'h0800, 12'h0fff};
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rd;
  logic [13:0] o_ext_pm_rdata, o_cpu_pm_rdata;
  logic        o_ext_pm_wr_en, o_ext_ee_rd_en, o_ext_ee_wr_en, o_cpu_ee_rd_en, o_cpu_ee_wr_en, o_self_wr_en;
  logic        o_pm_erase, o_ee_erase, o_watchdog_run, o_clock_input_pin_is_io, o_ext_clock, o_external_rc_mode;
  logic        o_crystal_pins_used, o_powerup_timer_en, o_brownout_trip_select, o_low_volt_programming_enable;
  logic        o_debug_en, o_clock_multiplier_enable, o_stack_reset;
  wire         i_hready = o_hreadyout;
  wire         i_ext_pm_rd, i_ext_pm_wr, i_ext_ee_rd, i_ext_ee_wr;
  wire  [13:0] i_pm_rdata;
  int          fail_count = 0, check_count = 0;
  cwp_config_loader dut_u (.*);
  cwp_prog_model #(.DATA(PM)) prog_u (.i_mclk, .i_go(go), .o_pm_rdata(i_pm_rdata),
    .o_strobe({i_ext_pm_rd, i_ext_pm_wr, i_ext_ee_rd, i_ext_ee_wr}));
  always #20 i_mclk = ~i_mclk;
  // Erase pulses last one cycle, so they are caught in sticky flags.
  always @(posedge i_mclk) begin
    pm_seen <= pm_seen | o_pm_erase;
    ee_seen <= ee_seen | o_ee_erase;
  end
  // ==========================================================================
  // Bus and check tasks.
  // ==========================================================================
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge i_mclk);
    i_hsel   <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr  <= a;
    i_hwrite <= w;
    do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hsel   <= 1'b0;
    i_hwdata <= d;
    do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(n, e, rd);
    chk("hresp", 32'h0000_0000, o_hresp);
  endtask
  // Decoded outputs follow a written word one edge after the write ends.
  task automatic step();
    @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic ext(input logic p, input logic e);
    @(posedge i_mclk) go <= 1'b1;
    @(posedge i_mclk) go <= 1'b0;
    {i_cpu_ee_rd, i_cpu_ee_wr} <= 2'b11;
    @(posedge i_mclk) {i_cpu_ee_rd, i_cpu_ee_wr} <= 2'b00;
    @(negedge i_mclk);
    chk("pm_rdata", p ? PM : 14'h0000, o_ext_pm_rdata);
    chk("pm_wr", p, o_ext_pm_wr_en);
    chk("cpu_pm", PM, o_cpu_pm_rdata);
    chk("ee_ext", {e, e}, {o_ext_ee_rd_en, o_ext_ee_wr_en});
    chk("ee_cpu", 2'b11, {o_cpu_ee_rd_en, o_cpu_ee_wr_en});
  endtask
  task automatic sf(input logic e);
    @(posedge i_mclk) i_stack_fault <= 1'b1;
    @(posedge i_mclk) i_stack_fault <= 1'b0;
    @(negedge i_mclk);
    chk("stack_rst", e, o_stack_reset);
    chk("mult", e, o_clock_multiplier_enable);
    chk("cw2_fields", {e, e}, {o_low_volt_programming_enable, o_brownout_trip_select});
    chk("debug_on", 1'b0, o_debug_en);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================================
  // Test sequence.
  // ==========================================================================
  initial begin
    repeat (8) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rdc("cfg1", 32'h0002_001c, 32'h0000_3fff);
    rdc("cfg2", 32'h0002_0020, 32'h0000_3fff);
    xfer(32'h0002_0018, 1'b1, 32'h0000_0000);
    rdc("ident", 32'h0002_0018, {18'h0, cwp_pkg::PART_ID_DFLT, cwp_pkg::STEP_ID_DFLT});
    rdc("unmapped", 32'h0002_0100, 32'h0000_0000);
    for (int i = 0; i < 4; i++) xfer(32'h0002_0000 + i * 4, 1'b1, 32'h0000_1a50 + i);
    for (int i = 0; i < 4; i++) rdc("user_id", 32'h0002_0000 + i * 4, 32'h0000_1a50 + i);
    // Every clock code and watchdog mode, with sleep and the software bit toggled.
    for (int i = 0; i < 8; i++) begin
      {i_sleep, i_software_watchdog_on} <= {2{i[2]}};
      xfer(32'h0002_001c, 1'b1, 32'h0000_3fe0 | {i[1:0], i[2:0]});
      step();
      chk("wdt_mode", i % 4, o_watchdog_enable_mode);
      chk("wdt_run", i % 4 == 3 || (i % 4 == 2 && !i[2]) || (i % 4 == 1 && i[2]), o_watchdog_run);
      chk("osc", i, o_clock_source_select);
      chk("osc_pins", {i == 4, i > 4, i == 3, i < 3},
          {o_clock_input_pin_is_io, o_ext_clock, o_external_rc_mode, o_crystal_pins_used});
      chk("drive", (i > 4) ? i - 4 : (i < 3) ? i + 1 : 0, o_drive_level);
      chk("pwrup", {1'b0, 2'b11}, {o_powerup_timer_en, o_brownout_mode});
    end
    ext(1'b1, 1'b1);
    xfer(32'h0002_001c, 1'b1, 32'h0000_3e7f);
    step();
    ext(1'b0, 1'b0);
    // Guard sizes while both protections are on; debug bit kept at one.
    for (int g = 0; g < 4; g++) begin
      xfer(32'h0002_0020, 1'b1, 32'h0000_3ffc | g);
      for (int k = 0; k < 5; k++) begin
        @(posedge i_mclk);
        i_self_wr_req  <= 1'b1;
        i_self_wr_addr <= sa[k];
        @(posedge i_mclk) i_self_wr_req <= 1'b0;
        @(negedge i_mclk);
        chk("self_wr", {1'b0, sa[k]} >= (g == 3 ? cwp_pkg::GUARD_NONE : g == 2 ? cwp_pkg::GUARD_SMALL :
            g == 1 ? cwp_pkg::GUARD_HALF : cwp_pkg::GUARD_ALL), o_self_wr_en);
      end
    end
    // Both words protected, watchdog always on, multiplier on, no self-write pending.
    rdc("status", 32'h0002_0044, 32'h0000_001b);
    sf(1'b1);
    xfer(32'h0002_0020, 1'b1, 32'h0000_18ff);
    step();
    sf(1'b0);
    chk("no_erase", 2'b00, {pm_seen, ee_seen});
    xfer(32'h0002_0040, 1'b1, 32'h0000_0001);
    step();
    step();
    chk("erase", 2'b11, {pm_seen, ee_seen});
    rdc("cfg1_erased", 32'h0002_001c, 32'h0000_3fff);
    ext(1'b1, 1'b1);
    report_and_stop();
  end
  // A hung handshake ends the run as a mismatch.
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule // tb
